// ### tb/rsl_drive_model.sv
// Motor drive and feedback sensor model facing the speed command output.
// Assumes the controller's clock; the shaft follows the command one cycle late.
`timescale 1ns/1ps
`default_nettype none
module rsl_drive_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Drive side
  input wire logic [15:0] speed_i,
  input wire logic fb_en_i,
  // Feedback sensor
  output logic fb_pulse_o,
  output logic [15:0] feedback_o
);
  logic [1:0] div_q; // Pulse spacing divider

  // Shaft speed tracks the command; a lost sensor reads no speed at all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feedback_o <= 16'h0000;
    end else if (fb_en_i) begin
      feedback_o <= speed_i;
    end else begin
      feedback_o <= 16'h0000;
    end
  end

  // One pulse every fourth cycle while the sensor works
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 2'h0;
      fb_pulse_o <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      fb_pulse_o <= fb_en_i && (div_q == 2'h3);
    end
  end
endmodule : rsl_drive_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the run/stop/setpoint logic, bus tasks plus contact sequences.
// Assumes the drive model file is compiled first; short repeat and loss counts.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic clk_i, rst_i, cyc, stb, we, ack, fb_pulse, fb_en, d1, d2; // Bus and flags
  logic [7:0] adr; // Bus address
  logic [31:0] wdat, rdat, rd; // Bus data
  logic [15:0] lead, analog, fbk, speed, s0; // Process values
  logic [1:0] alarm; // External alarms
  rsl_pkg::rsl_contacts_t c; // Operator contacts
  int bad_count, compares; // Result counters
  // Clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  rsl_ctrl #(.REPEAT_CYCLES(8), .FB_LOSS_CYCLES(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .contacts_i(c),
    .meas_i({lead, fbk, analog}), .fb_pulse_i(fb_pulse), .alarm_i(alarm),
    .speed_cmd_o(speed), .dout1_o(d1), .dout2_o(d2));
  rsl_drive_model pm (.clk_i(clk_i), .rst_i(rst_i), .speed_i(speed), .fb_en_i(fb_en),
    .fb_pulse_o(fb_pulse), .feedback_o(fbk));
  // Verdict and end of run
  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask : wb
  // Bounded wait for a speed command value
  task automatic wait_speed(input logic [15:0] v);
    int n;
    n = 0;
    while (speed !== v && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("speed reached", v, speed)
    if (speed !== v) test_done();
  endtask : wait_speed
  // Momentary run contact
  task automatic run_pulse();
    @(posedge clk_i);
    c.run <= 1'b1;
    @(posedge clk_i);
    c.run <= 1'b0;
  endtask : run_pulse
  task automatic state_is(input logic [1:0] s);
    wb(1'b0, rsl_pkg::A_STATUS, 32'h0);
    `CHK("state", s, rd[3:2])
  endtask : state_is
  localparam logic [7:0] RA [6] = '{8'h04, 8'h14, 8'h18, 8'h1C, 8'h30, 8'hFC};
  localparam logic [31:0] RV [6] = '{32'h1, 32'h1, 32'h100, 32'h4, 32'h30, 32'h0};
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    c = '0;
    c.rstop = 1'b1;
    c.fstop = 1'b1;
    {lead, analog, alarm, fb_en} = {16'h0080, 16'h0, 2'h0, 1'b1};
    tick(2);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, RA[i], 32'h0);
      `CHK("reset value", RV[i], rd)
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) wb(1'b1, rsl_pkg::A_SP0 + 8'(4 * i), 32'(64 * (i + 1)));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      c.mode <= i[1];
      c.sp_sel <= i[0];
      @(posedge clk_i);
      c.up <= 1'b1;
      @(posedge clk_i);
      c.up <= 1'b0;
      wb(1'b0, rsl_pkg::A_SP0 + 8'(4 * i), 32'h0);
      `CHK("stepped setpoint", 32'(64 * (i + 1) + 1), rd)
      wb(1'b0, rsl_pkg::A_STATUS, 32'h0);
      `CHK("setpoint index", 2'(i), rd[7:6])
    end
    @(posedge clk_i);
    c.up <= 1'b1;
    tick(20);
    c.up <= 1'b0;
    wb(1'b0, 8'h2C, 32'h0);
    `CHK("up repeat", 32'h104, rd)
    @(posedge clk_i);
    c.shared <= 1'b1;
    @(posedge clk_i);
    c.shared <= 1'b0;
    wb(1'b0, 8'h2C, 32'h0);
    `CHK("down step", 32'h103, rd)
    @(posedge clk_i);
    c.shared <= 1'b1;
    tick(20);
    c.shared <= 1'b0;
    {c.mode, c.sp_sel} <= 2'b00;
    wb(1'b0, 8'h2C, 32'h0);
    `CHK("down repeat", 32'h100, rd)
    $display("test setpoints done");
    wb(1'b1, rsl_pkg::A_INFUNC, 32'(rsl_pkg::INFUNC_LOOP));
    c.shared <= 1'b1;
    wb(1'b0, rsl_pkg::A_STATUS, 32'h0);
    `CHK("open loop flag", 1'b1, rd[9])
    c.rstop <= 1'b0;
    run_pulse();
    state_is(2'h0);
    c.rstop <= 1'b1;
    run_pulse();
    tick(4);
    state_is(2'h1);
    `CHK("open loop speed", 16'h0041, speed)
    c.mode <= 1'b1;
    tick(4);
    `CHK("follower speed", 16'h0060, speed)
    c.mode <= 1'b0;
    wb(1'b1, rsl_pkg::A_ANALOG, 32'(rsl_pkg::AN_SETPT));
    analog <= 16'h0055;
    tick(3);
    `CHK("analog setpoint", 16'h0055, speed)
    wb(1'b0, rsl_pkg::A_SPEED, 32'h0);
    `CHK("speed readback", 32'h0055, rd)
    wb(1'b1, rsl_pkg::A_TUNE, 32'h14);
    c.mode <= 1'b1;
    tick(3);
    `CHK("offset speed", 16'h0116, speed)
    wb(1'b1, rsl_pkg::A_TUNE, 32'(rsl_pkg::GAIN_RST));
    c.mode <= 1'b0;
    wb(1'b1, rsl_pkg::A_ANALOG, 32'(rsl_pkg::AN_NONE));
    wb(1'b1, rsl_pkg::A_OUT1, 32'(rsl_pkg::OUT_DRIVE));
    wb(1'b1, rsl_pkg::A_OUT2, 32'(rsl_pkg::OUT_ALARM0));
    alarm <= 2'b01;
    tick(3);
    `CHK("out1 drive", 1'b1, d1)
    `CHK("out2 alarm0", 1'b1, d2)
    alarm <= 2'b10;
    tick(3);
    `CHK("out2 alarm0 off", 1'b0, d2)
    wb(1'b1, rsl_pkg::A_OUT2, 32'(rsl_pkg::OUT_ALARM1));
    tick(3);
    `CHK("out2 alarm1", 1'b1, d2)
    wb(1'b1, rsl_pkg::A_DECEL, 32'h2);
    c.rstop <= 1'b0;
    @(posedge clk_i);
    c.rstop <= 1'b1;
    tick(2);
    s0 = speed;
    tick(1);
    `CHK("ramp step", s0 - 16'h2, speed)
    wait_speed(16'h0000);
    tick(3);
    state_is(2'h0);
    `CHK("out1 idle", 1'b0, d1)
    $display("test run and ramp done");
    c.rstop <= 1'b0;
    c.jog <= 1'b1;
    tick(3);
    `CHK("jog refused", 16'h0000, speed)
    c.rstop <= 1'b1;
    tick(3);
    `CHK("jog speed", 16'h0100, speed)
    c.jog <= 1'b0;
    tick(2);
    `CHK("jog released", 16'h0000, speed)
    run_pulse();
    tick(4);
    {c.rstop, c.fstop} <= 2'b00;
    @(posedge clk_i);
    {c.rstop, c.fstop} <= 2'b11;
    tick(1);
    `CHK("fast stop", 16'h0000, speed)
    state_is(2'h0);
    wb(1'b1, rsl_pkg::A_CTRL, 32'h1);
    state_is(2'h1);
    wb(1'b1, rsl_pkg::A_CTRL, 32'h4);
    state_is(2'h0);
    $display("test jog and stops done");
    wb(1'b1, rsl_pkg::A_INFUNC, 32'(rsl_pkg::INFUNC_DOWN));
    c.shared <= 1'b0;
    run_pulse();
    tick(300);
    `CHK("closed loop", 1'b1, (speed >= 16'h0031 && speed <= 16'h0040))
    wb(1'b1, rsl_pkg::A_OUT1, 32'(rsl_pkg::OUT_FBLOSS));
    wb(1'b1, rsl_pkg::A_SP0, 32'hF000);
    fb_en <= 1'b0;
    wait_speed(rsl_pkg::SPEED_FULL);
    tick(2);
    `CHK("out1 loss", 1'b1, d1)
    wb(1'b0, rsl_pkg::A_STATUS, 32'h0);
    `CHK("loss flag", 1'b1, rd[8])
    $display("test feedback done");
    test_done();
  end
endmodule : tb
`default_nettype wire

// ### verilog/rsl_ctrl.sv
// Run/stop latching, jog, setpoint select and scroll, loop select and output routing.
// Assumes contacts already debounced and synchronous to clk_i; Wishbone classic slave.
// How it works
// R1 - Run pulse latches running state
// R2 - Run only with both stops closed
// R3 - Jog speed only while jog held
// R4 - Jog needs stops closed, run open
// R5 - Ramped stop latches, ramps speed down
// R6 - Fast stop latches, zeroes speed at once
// R7 - Mode contact picks master or follower scaling
// R8 - Mode and select pick setpoint 1..4
// R9 - Up closure adds one unit
// R10 - Held up repeats every half second
// R11 - Function param picks down or loop
// R12 - Down closure subtracts one unit
// R13 - Held down repeats every half second
// R14 - Closed loop drives error to zero
// R15 - Open loop follows setpoint only
// R16 - Lost feedback drives command full scale
// R17 - Output one follows its allocation
// R18 - Output two follows its allocation
// R19 - Analog allocation picks its use
// R20 - Host writes params, reads status, controls
// R21 - Stops clear run; fast stop wins
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rsl_ctrl #(
  parameter int unsigned REPEAT_CYCLES = rsl_pkg::REPEAT_CYC,
  parameter int unsigned FB_LOSS_CYCLES = rsl_pkg::FB_LOSS_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Operator contacts and process inputs
  input wire rsl_pkg::rsl_contacts_t contacts_i,
  input wire rsl_pkg::rsl_meas_t meas_i,
  input wire logic fb_pulse_i,
  input wire logic [1:0] alarm_i,
  // Drive side
  output logic [15:0] speed_cmd_o,
  output logic dout1_o,
  output logic dout2_o
);
  // Output routing, shared by both digital outputs
  function automatic logic out_route(input logic [2:0] alloc, input logic drive,
                                     input logic loss, input logic [1:0] alm);
    case (alloc)
      rsl_pkg::OUT_DRIVE: out_route = drive;
      rsl_pkg::OUT_FBLOSS: out_route = loss;
      rsl_pkg::OUT_ALARM0: out_route = alm[0];
      rsl_pkg::OUT_ALARM1: out_route = alm[1];
      default: out_route = 1'b0;
    endcase
  endfunction : out_route

  // Saturating add of a signed step to an unsigned value
  function automatic logic [15:0] sat_add(input logic [15:0] v, input logic signed [17:0] s);
    logic signed [18:0] t;
    t = $signed({3'b000, v}) + 19'(s);
    if (t < 0) sat_add = rsl_pkg::SPEED_ZERO;
    else if (t > $signed({3'b000, rsl_pkg::SPEED_FULL})) sat_add = rsl_pkg::SPEED_FULL;
    else sat_add = t[15:0];
  endfunction : sat_add

  // Configuration registers
  logic [1:0] infunc_q;          // Shared input function
  logic [2:0] out1_q;            // Output one allocation
  logic [2:0] out2_q;            // Output two allocation
  logic [1:0] analog_q;          // Analog allocation
  logic [15:0] decel_q;          // Ramp step
  logic [15:0] jog_q;            // Jog speed
  logic [3:0] gain_q;            // Integrator shift
  logic ofs_mode_q;              // Closed mode contact means offset mode
  logic [15:0] setpt_q [4];      // Setpoints 1..4
  // Control state
  rsl_pkg::rsl_state_t state_q;
  logic [15:0] speed_q;
  logic rstop_lat_q;             // Latched ramped stop
  logic fstop_lat_q;             // Latched fast stop
  logic up_q, dn_q;              // Previous contact levels
  logic [31:0] up_cnt_q, dn_cnt_q;
  logic [31:0] fb_cnt_q;
  logic fb_lost_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;

  // Bus decode
  logic bus_req, bus_wr;
  logic [2:0] rem_q;             // Remote run/rstop/fstop pulses
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & wb_ack_q & wb_sel_i[0];

  // Derived selection
  logic [1:0] sp_idx;            // Active setpoint index
  logic dn_mode, loop_open;
  logic up_step, dn_step;
  assign sp_idx = {contacts_i.mode, contacts_i.sp_sel}; // see R8 see R7
  assign dn_mode = (infunc_q == rsl_pkg::INFUNC_DOWN); // see R11
  assign loop_open = (infunc_q == rsl_pkg::INFUNC_LOOP) & contacts_i.shared; // see R11

  // Stop and start conditions
  logic stops_ok, run_ok, jog_ok, fstop_ev, rstop_ev;
  assign stops_ok = contacts_i.rstop & contacts_i.fstop;
  assign fstop_ev = ~contacts_i.fstop | rem_q[rsl_pkg::CTRL_FSTOP]; // see R6
  assign rstop_ev = ~contacts_i.rstop | rem_q[rsl_pkg::CTRL_RSTOP]; // see R5
  assign run_ok = (contacts_i.run | rem_q[rsl_pkg::CTRL_RUN]) & stops_ok; // see R2
  assign jog_ok = contacts_i.jog & stops_ok & ~contacts_i.run; // see R4

  // Target computation with analog allocation
  logic [15:0] sp_val, lead_val, target, fb_val;
  logic [31:0] fol_prod;
  always_comb begin
    sp_val = setpt_q[sp_idx];
    lead_val = (analog_q == rsl_pkg::AN_FREQ) ? meas_i.analog : meas_i.lead; // see R19
    fol_prod = 32'(sp_val) * 32'(lead_val);
    if (!contacts_i.mode) begin
      // Master scaling
      target = (analog_q == rsl_pkg::AN_SETPT) ? meas_i.analog : sp_val; // see R19 see R7
    end else if (ofs_mode_q) begin
      // Offset mode adds analog offset
      target = (analog_q == rsl_pkg::AN_SETPT) ? sat_add(sp_val, 18'(meas_i.analog)) : sp_val;
    end else begin
      // Follower ratio scaling
      target = (analog_q == rsl_pkg::AN_SETPT) ? meas_i.analog
             : fol_prod[rsl_pkg::FOL_SHIFT +: 16]; // see R7
    end
    fb_val = fb_lost_q ? rsl_pkg::SPEED_ZERO : meas_i.feedback; // see R16
  end

  // Closed-loop integrator step
  logic signed [17:0] err, corr;
  assign err = $signed({2'b00, target}) - $signed({2'b00, fb_val}); // see R14
  assign corr = err >>> gain_q;

  // Scroll edge and hold-repeat detection
  assign up_step = contacts_i.up & (~up_q | (up_cnt_q == REPEAT_CYCLES - 1)); // see R9 see R10
  assign dn_step = dn_mode & contacts_i.shared
                 & (~dn_q | (dn_cnt_q == REPEAT_CYCLES - 1)); // see R12 see R13

  // Repeat timers, restarting on each step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      up_cnt_q <= 32'h0000_0000;
      dn_cnt_q <= 32'h0000_0000;
    end else begin
      up_q <= contacts_i.up;
      dn_q <= dn_mode & contacts_i.shared;
      up_cnt_q <= (!contacts_i.up || up_step) ? 32'h0000_0000 : up_cnt_q + 32'h0000_0001;
      dn_cnt_q <= (!(dn_mode && contacts_i.shared) || dn_step) ? 32'h0000_0000
                : dn_cnt_q + 32'h0000_0001;
    end
  end

  // Feedback loss watchdog
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fb_cnt_q <= 32'h0000_0000;
      fb_lost_q <= 1'b0;
    end else if (fb_pulse_i) begin
      fb_cnt_q <= 32'h0000_0000;
      fb_lost_q <= 1'b0;
    end else if (fb_cnt_q == FB_LOSS_CYCLES - 1) begin
      fb_lost_q <= 1'b1;
    end else begin
      fb_cnt_q <= fb_cnt_q + 32'h0000_0001;
    end
  end

  // Stop latches; a new event wins over the clear on start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstop_lat_q <= 1'b1;
      fstop_lat_q <= 1'b1;
    end else begin
      if (fstop_ev) fstop_lat_q <= 1'b1; // see R6
      else if (run_ok || jog_ok) fstop_lat_q <= 1'b0;
      if (rstop_ev) rstop_lat_q <= 1'b1; // see R5
      else if (run_ok || jog_ok) rstop_lat_q <= 1'b0;
    end
  end

  // Run/jog/ramp state and speed command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= rsl_pkg::ST_IDLE;
      speed_q <= rsl_pkg::SPEED_ZERO;
    end else if (fstop_ev) begin
      state_q <= rsl_pkg::ST_IDLE; // see R6 see R21
      speed_q <= rsl_pkg::SPEED_ZERO;
    end else begin
      unique case (state_q)
        rsl_pkg::ST_IDLE: begin
          speed_q <= rsl_pkg::SPEED_ZERO;
          if (run_ok) state_q <= rsl_pkg::ST_RUN; // see R1 see R2
          else if (jog_ok) state_q <= rsl_pkg::ST_JOG; // see R4
        end
        rsl_pkg::ST_RUN: begin
          if (rstop_ev) state_q <= rsl_pkg::ST_RAMP; // see R5 see R21
          else if (loop_open) speed_q <= target; // see R15
          else speed_q <= sat_add(speed_q, corr); // see R14 see R16
        end
        rsl_pkg::ST_JOG: begin
          if (!contacts_i.jog || rstop_ev) begin
            state_q <= rsl_pkg::ST_IDLE; // see R3
            speed_q <= rsl_pkg::SPEED_ZERO;
          end else begin
            speed_q <= jog_q; // see R3
          end
        end
        rsl_pkg::ST_RAMP: begin
          speed_q <= sat_add(speed_q, -$signed({2'b00, decel_q})); // see R5
          if (speed_q <= decel_q) state_q <= rsl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Configuration and setpoint registers; bus write wins over scroll
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      infunc_q <= rsl_pkg::INFUNC_RST;
      out1_q <= rsl_pkg::ALLOC_RST;
      out2_q <= rsl_pkg::ALLOC_RST;
      analog_q <= rsl_pkg::AN_NONE;
      decel_q <= rsl_pkg::DECEL_RST;
      jog_q <= rsl_pkg::JOG_RST;
      gain_q <= rsl_pkg::GAIN_RST;
      ofs_mode_q <= 1'b0;
      for (int i = 0; i < 4; i++) setpt_q[i] <= rsl_pkg::SPEED_ZERO;
    end else begin
      // Scroll steps on the active setpoint only
      if (up_step && !dn_step) begin
        setpt_q[sp_idx] <= sat_add(setpt_q[sp_idx], 18'sd1); // see R9 see R10
      end else if (dn_step && !up_step) begin
        setpt_q[sp_idx] <= sat_add(setpt_q[sp_idx], -18'sd1); // see R12 see R13
      end
      if (bus_wr) begin
        unique case (wb_adr_i)
          rsl_pkg::A_INFUNC: infunc_q <= wb_dat_i[1:0]; // see R20
          rsl_pkg::A_OUT1: out1_q <= wb_dat_i[2:0];
          rsl_pkg::A_OUT2: out2_q <= wb_dat_i[2:0];
          rsl_pkg::A_ANALOG: analog_q <= wb_dat_i[1:0];
          rsl_pkg::A_DECEL: decel_q <= wb_dat_i[15:0];
          rsl_pkg::A_JOG: jog_q <= wb_dat_i[15:0];
          rsl_pkg::A_TUNE: begin
            gain_q <= wb_dat_i[3:0];
            ofs_mode_q <= wb_dat_i[rsl_pkg::TUNE_OFS];
          end
          rsl_pkg::A_SP0, rsl_pkg::A_SP0 + 8'h04, rsl_pkg::A_SP0 + 8'h08,
          rsl_pkg::A_SP0 + 8'h0C: setpt_q[wb_adr_i[3:2]] <= wb_dat_i[15:0];
          default: ;
        endcase
      end
    end
  end

  // Remote control pulses, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) rem_q <= 3'h0;
    else rem_q <= (bus_wr && wb_adr_i == rsl_pkg::A_CTRL) ? wb_dat_i[2:0] : 3'h0; // see R20
  end

  // Bus answer one cycle after the request, read data captured then
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= bus_req & ~wb_ack_q;
      unique case (wb_adr_i)
        rsl_pkg::A_INFUNC: wb_dat_q <= {30'h0, infunc_q};
        rsl_pkg::A_OUT1: wb_dat_q <= {29'h0, out1_q};
        rsl_pkg::A_OUT2: wb_dat_q <= {29'h0, out2_q};
        rsl_pkg::A_ANALOG: wb_dat_q <= {30'h0, analog_q};
        rsl_pkg::A_DECEL: wb_dat_q <= {16'h0, decel_q};
        rsl_pkg::A_JOG: wb_dat_q <= {16'h0, jog_q};
        rsl_pkg::A_TUNE: wb_dat_q <= {27'h0, ofs_mode_q, gain_q};
        rsl_pkg::A_SP0, rsl_pkg::A_SP0 + 8'h04, rsl_pkg::A_SP0 + 8'h08,
        rsl_pkg::A_SP0 + 8'h0C: wb_dat_q <= {16'h0, setpt_q[wb_adr_i[3:2]]};
        rsl_pkg::A_STATUS: wb_dat_q <= {22'h0, loop_open, fb_lost_q, sp_idx,
                                        fstop_lat_q, rstop_lat_q, 2'(state_q),
                                        dout2_o, dout1_o}; // see R20
        rsl_pkg::A_SPEED: wb_dat_q <= {16'h0, speed_q};
        default: wb_dat_q <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // Drive-side outputs from flip-flops
  logic drive_en;
  assign drive_en = (state_q != rsl_pkg::ST_IDLE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout1_o <= 1'b0;
      dout2_o <= 1'b0;
    end else begin
      dout1_o <= out_route(out1_q, drive_en, fb_lost_q, alarm_i); // see R17
      dout2_o <= out_route(out2_q, drive_en, fb_lost_q, alarm_i); // see R18
    end
  end
  assign speed_cmd_o = speed_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run_press;
    state_q == rsl_pkg::ST_IDLE && run_ok && !fstop_ev;
  endsequence

  a_run_latch: assert property (s_run_press |=> state_q == rsl_pkg::ST_RUN) // see R1
    else $error("run press not latched");
  a_run_refused: assert property (!stops_ok && !rem_q[rsl_pkg::CTRL_RUN] |=> state_q != rsl_pkg::ST_RUN
                                  || $past(state_q) == rsl_pkg::ST_RUN) // see R2
    else $error("run entered with a stop open");
  a_jog_speed: assert property (state_q == rsl_pkg::ST_JOG && contacts_i.jog && !rstop_ev
                                && !fstop_ev |=> speed_q == $past(jog_q)) // see R3
    else $error("jog speed wrong");
  a_jog_gate: assert property ($rose(state_q == rsl_pkg::ST_JOG)
                               |-> $past(contacts_i.jog && stops_ok && !contacts_i.run)) // see R4
    else $error("jog entered illegally");
  a_rstop_ramp: assert property (state_q == rsl_pkg::ST_RUN && rstop_ev && !fstop_ev
                                 |=> state_q == rsl_pkg::ST_RAMP ##1 speed_q <= $past(speed_q)) // see R5
    else $error("ramped stop did not ramp");
  a_fstop_zero: assert property (fstop_ev |=> speed_q == rsl_pkg::SPEED_ZERO
                                 && state_q == rsl_pkg::ST_IDLE) // see R6 see R21
    else $error("fast stop did not zero speed");
  a_up_step: assert property ($rose(contacts_i.up) && !dn_step && !bus_wr
                              |=> setpt_q[$past(sp_idx)] == sat_add($past(sp_val), 18'sd1)) // see R9
    else $error("scroll up missed");
  a_open_loop: assert property (state_q == rsl_pkg::ST_RUN && loop_open && !rstop_ev
                                && !fstop_ev |=> speed_q == $past(target)) // see R15
    else $error("open loop not following setpoint");
  a_out_one: assert property (out1_q == rsl_pkg::OUT_DRIVE && $stable(out1_q)
                              |=> dout1_o == $past(drive_en)) // see R17
    else $error("output one misrouted");
  a_bus_ack: assert property (bus_req && !wb_ack_q |=> wb_ack_q ##1 !wb_ack_q) // see R20
    else $error("bus ack not one cycle");

  // Watchdog, second output, scroll down, analog use and jog release
  sequence s_fb_silent;
    !fb_pulse_i && fb_cnt_q == FB_LOSS_CYCLES - 1;
  endsequence

  a_loss_flag: assert property (s_fb_silent |=> fb_lost_q) // see R16
    else $error("feedback loss not flagged");
  a_loss_clear: assert property (fb_pulse_i |=> !fb_lost_q) // see R16
    else $error("feedback loss not cleared");
  a_out_two: assert property (out2_q == rsl_pkg::OUT_ALARM1 && $stable(out2_q) // see R18
                              |=> dout2_o == $past(alarm_i[1]))
    else $error("output two misrouted");
  a_dn_step: assert property ($rose(dn_mode && contacts_i.shared) // see R12
                              && !up_step && !bus_wr
                              |=> setpt_q[$past(sp_idx)] == sat_add($past(sp_val), -18'sd1))
    else $error("scroll down missed");
  a_analog_setpt: assert property (state_q == rsl_pkg::ST_RUN && loop_open // see R19
                                   && !contacts_i.mode && analog_q == rsl_pkg::AN_SETPT
                                   && !rstop_ev && !fstop_ev |=> speed_q == $past(meas_i.analog))
    else $error("analog setpoint not applied");
  a_jog_exit: assert property (state_q == rsl_pkg::ST_JOG && !contacts_i.jog // see R3
                               |=> speed_q == rsl_pkg::SPEED_ZERO && state_q == rsl_pkg::ST_IDLE)
    else $error("jog not released");
endmodule : rsl_ctrl
`default_nettype wire

// ### verilog/rsl_pkg.sv
// Shared constants and carriers for the run/stop/setpoint control logic.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
package rsl_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 40000000;     // System clock rate
  localparam int unsigned REPEAT_MS = 500;       // Scroll auto-repeat period
  localparam int unsigned REPEAT_CYC = CLK_HZ / 1000 * REPEAT_MS; // Rounds down
  localparam int unsigned FB_LOSS_MS = 100;      // Feedback silence before loss
  localparam int unsigned FB_LOSS_CYC = CLK_HZ / 1000 * FB_LOSS_MS;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;         // Remote run/stop pulses
  localparam logic [7:0] A_INFUNC = 8'h04;       // Shared input function
  localparam logic [7:0] A_OUT1 = 8'h08;         // Output one allocation
  localparam logic [7:0] A_OUT2 = 8'h0C;         // Output two allocation
  localparam logic [7:0] A_ANALOG = 8'h10;       // Analog input allocation
  localparam logic [7:0] A_DECEL = 8'h14;        // Ramp step per clock
  localparam logic [7:0] A_JOG = 8'h18;          // Jog speed
  localparam logic [7:0] A_TUNE = 8'h1C;         // Gain shift, offset-mode enable
  localparam logic [7:0] A_SP0 = 8'h20;          // Setpoints 1..4 at 0x20..0x2C
  localparam logic [7:0] A_STATUS = 8'h30;       // Live state
  localparam logic [7:0] A_SPEED = 8'h34;        // Speed command readback

  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RSTOP = 1;
  localparam int CTRL_FSTOP = 2;
  localparam int TUNE_OFS = 4;                   // Offset mode bit in tune reg

  // Reset values
  localparam logic [1:0] INFUNC_RST = 2'h1;
  localparam logic [2:0] ALLOC_RST = 3'h0;
  localparam logic [15:0] DECEL_RST = 16'h0001;
  localparam logic [15:0] JOG_RST = 16'h0100;
  localparam logic [3:0] GAIN_RST = 4'h4;
  localparam logic [15:0] SPEED_FULL = 16'hFFFF;
  localparam logic [15:0] SPEED_ZERO = 16'h0000;

  // Shared input function codes
  localparam logic [1:0] INFUNC_DOWN = 2'h1;
  localparam logic [1:0] INFUNC_LOOP = 2'h2;

  // Analog input allocation codes
  localparam logic [1:0] AN_NONE = 2'h0;
  localparam logic [1:0] AN_FREQ = 2'h1;         // Replaces lead frequency
  localparam logic [1:0] AN_SETPT = 2'h2;        // Replaces setpoint / offset

  // Digital output allocation codes
  localparam logic [2:0] OUT_OFF = 3'h0;
  localparam logic [2:0] OUT_DRIVE = 3'h1;
  localparam logic [2:0] OUT_FBLOSS = 3'h2;
  localparam logic [2:0] OUT_ALARM0 = 3'h3;
  localparam logic [2:0] OUT_ALARM1 = 3'h4;

  // Follower scaling shift
  localparam int FOL_SHIFT = 8;

  // Operating states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_JOG = 2'b10,
    ST_RAMP = 2'b11
  } rsl_state_t;

  // Operator contacts, one bit each, 1 = closed to common
  typedef struct packed {
    logic run;
    logic rstop;
    logic fstop;
    logic jog;
    logic mode;
    logic sp_sel;
    logic up;
    logic shared;
  } rsl_contacts_t;

  // Process measurements
  typedef struct packed {
    logic [15:0] lead;
    logic [15:0] feedback;
    logic [15:0] analog;
  } rsl_meas_t;
endpackage : rsl_pkg
